// ===== rtl/pmx_pin_mux.sv
// Pin multiplexing and reset-time mode selection for a DSP core.
// Assumes mclk_i runs while sys_rst_i is high; pads resolve via oe_n.
`timescale 1ns/1ns
`default_nettype none

// Function
// - straps sampled in reset, then general flags
// - memory strap low selects full memory mode
// - bus pins fixed at reset, serial reconfigurable
// - interrupt and flag functions coexist on pins
// - enabled interrupt fires however pin is asserted
// - serial port b pins become interrupts, flags
// - internal serial clock stays usable when reassigned
// - dual and port b interrupts select edge or level sensitivity
// - full mode byte DMA, host mode host DMA
// - shared pins carry only latched mode signal
// - full mode drives address, data, byte address
// - host mode carries host port bus, strobes
module pmx_pin_mux (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Programmable flag pads, low four also mode straps
	input wire logic [pmx_pkg::FLAG_N-1:0] prog_flag_pin_i,
	output logic [pmx_pkg::FLAG_N-1:0] prog_flag_pin_o,
	output logic [pmx_pkg::FLAG_N-1:0] prog_flag_pin_oe_n_o,
	// Core flag control
	input wire logic [pmx_pkg::FLAG_N-1:0] prog_flag_dir_i,
	input wire logic [pmx_pkg::FLAG_N-1:0] prog_flag_out_i,
	output logic [pmx_pkg::FLAG_N-1:0] prog_flag_in_o,
	// Interrupt control and requests
	input wire logic [pmx_pkg::INT_N-1:0] interrupt_mask_i,
	input wire logic [2:0] int_edge_sel_i,
	input wire logic [pmx_pkg::INT_N-1:0] int_ack_i,
	output logic [pmx_pkg::INT_N-1:0] int_req_o,
	// Second serial port pads
	input wire logic [pmx_pkg::SPB_N-1:0] spb_pin_i,
	output logic [pmx_pkg::SPB_N-1:0] spb_pin_o,
	output logic [pmx_pkg::SPB_N-1:0] spb_pin_oe_n_o,
	// Second serial port core side and alternate use
	input wire logic port_b_alt_i,
	input wire logic [pmx_pkg::SPB_N-1:0] spb_out_i,
	input wire logic [pmx_pkg::SPB_N-1:0] spb_oe_n_i,
	output logic [pmx_pkg::SPB_N-1:0] spb_in_o,
	input wire logic port_b_flag_out_i,
	output logic port_b_flag_in_o,
	// Shared memory pads
	input wire logic [pmx_pkg::ADDR_W-1:0] addr_pad_i,
	output logic [pmx_pkg::ADDR_W-1:0] addr_pad_o,
	output logic [pmx_pkg::ADDR_W-1:0] addr_pad_oe_n_o,
	input wire logic [pmx_pkg::DATA_W-1:0] data_pad_i,
	output logic [pmx_pkg::DATA_W-1:0] data_pad_o,
	output logic [pmx_pkg::DATA_W-1:0] data_pad_oe_n_o,
	// Full memory mode core side
	input wire logic [pmx_pkg::ADDR_W-1:0] ext_address_bus_i,
	input wire logic [pmx_pkg::DATA_W-1:0] ext_data_bus_i,
	input wire logic ext_data_oe_i,
	output logic [pmx_pkg::DATA_W-1:0] ext_data_bus_o,
	input wire logic byte_dma_cycle_i,
	input wire logic [7:0] byte_dma_addr_i,
	// Host mode core side
	input wire logic [pmx_pkg::HOST_W-1:0] host_addr_data_bus_i,
	input wire logic host_addr_data_oe_i,
	output logic [pmx_pkg::HOST_W-1:0] host_addr_data_bus_o,
	output logic host_write_strobe_n_o,
	output logic host_read_strobe_n_o,
	output logic host_addr_latch_o,
	output logic host_port_select_n_o,
	input wire logic host_port_acknowledge_i,
	// Latched configuration
	output logic [pmx_pkg::STRAP_N-1:0] mode_straps_o,
	output logic byte_dma_port_en_o,
	output logic host_dma_port_en_o
);
	import pmx_pkg::*;

	logic [FLAG_N-1:0] pf_s1, pf_s2;
	logic [SPB_N-1:0] spb_s1, spb_s2;
	logic [ADDR_W-1:0] addr_s1, addr_s2;
	logic [DATA_W-1:0] data_s1, data_s2;
	logic in_rst_reg;
	logic [STRAP_N-1:0] strap_reg;
	pmx_mode_e mode_reg;
	logic host;
	logic alt_reg;
	logic [FLAG_N-1:0] pf_o_reg, pf_oe_n_reg;
	logic [INT_N-1:0] int_lvl, int_prev_reg, edge_mode, pend_reg, int_req_reg;
	logic [SPB_N-1:0] spb_o_reg, spb_oe_n_reg;
	logic [ADDR_W-1:0] addr_o_reg, addr_oe_n_reg;
	logic [DATA_W-1:0] data_o_reg, data_oe_n_reg;

	// Pad synchronisers, unreset so straps track during reset
	always_ff @(posedge mclk_i) begin
		pf_s1 <= prog_flag_pin_i;
		pf_s2 <= pf_s1;
		spb_s1 <= spb_pin_i;
		spb_s2 <= spb_s1;
		addr_s1 <= addr_pad_i;
		addr_s2 <= addr_s1;
		data_s1 <= data_pad_i;
		data_s2 <= data_s1;
	end

	// Marks reset plus the first edge after release
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			in_rst_reg <= 1'b1;
		else
			in_rst_reg <= 1'b0;
	end

	// Strap capture on every edge while in reset, frozen afterwards
	always_ff @(posedge mclk_i) begin
		if (in_rst_reg) begin
			strap_reg <= pf_s2[STRAP_N-1:0];
			mode_reg <= pf_s2[STRAP_MEM_BIT] ? PMX_HOST : PMX_FULL_MEM;
		end
	end
	assign mode_straps_o = strap_reg;
	assign host = (mode_reg == PMX_HOST);

	// Mode enables for the two DMA ports
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			byte_dma_port_en_o <= 1'b0;
			host_dma_port_en_o <= 1'b0;
		end else begin
			byte_dma_port_en_o <= !in_rst_reg && !host;
			host_dma_port_en_o <= !in_rst_reg && host;
		end
	end

	// Flag pads float during reset so straps can be read
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pf_o_reg <= '0;
			pf_oe_n_reg <= '1;
		end else begin
			pf_o_reg <= prog_flag_out_i;
			pf_oe_n_reg <= in_rst_reg ? '1 : ~prog_flag_dir_i;
		end
	end
	assign prog_flag_pin_o = pf_o_reg;
	assign prog_flag_pin_oe_n_o = pf_oe_n_reg;
	assign prog_flag_in_o = pf_s2;

	// Interrupt pin levels; a driven flag feeds its own interrupt
	always_comb begin
		int_lvl = LVL_IDLE;
		int_lvl[INT_DUAL] = pf_oe_n_reg[PF_DUAL] ? pf_s2[PF_DUAL]
			: pf_o_reg[PF_DUAL];
		int_lvl[INT_LVL_B] = pf_oe_n_reg[PF_LVL_B] ? pf_s2[PF_LVL_B]
			: pf_o_reg[PF_LVL_B];
		int_lvl[INT_LVL_A] = pf_oe_n_reg[PF_LVL_A] ? pf_s2[PF_LVL_A]
			: pf_o_reg[PF_LVL_A];
		int_lvl[INT_EDGE] = pf_oe_n_reg[PF_EDGE] ? pf_s2[PF_EDGE]
			: pf_o_reg[PF_EDGE];
		if (alt_reg) begin
			int_lvl[INT_SPB0] = spb_s2[SPB_RFS];
			int_lvl[INT_SPB1] = spb_s2[SPB_TFS];
		end
	end

	// Sensitivity per slot
	assign edge_mode = {int_edge_sel_i[2], int_edge_sel_i[1], 1'b1,
		1'b0, 1'b0, int_edge_sel_i[0]};

	// Falling edges latch; a new edge beats an acknowledge
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			int_prev_reg <= LVL_IDLE;
			pend_reg <= INT_RST;
		end else begin
			int_prev_reg <= int_lvl;
			pend_reg <= (pend_reg & ~int_ack_i)
				| (int_prev_reg & ~int_lvl & edge_mode);
		end
	end

	// Masked requests toward the sequencer
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			int_req_reg <= INT_RST;
		else
			int_req_reg <= interrupt_mask_i
				& ((edge_mode & pend_reg) | (~edge_mode & ~int_lvl));
	end
	assign int_req_o = int_req_reg;

	// Serial port b pin routing, changeable at any time
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			alt_reg <= 1'b0;
			spb_o_reg <= '0;
			spb_oe_n_reg <= '1;
			spb_in_o <= '0;
			port_b_flag_in_o <= 1'b0;
		end else begin
			alt_reg <= port_b_alt_i;
			spb_o_reg <= spb_out_i;
			spb_oe_n_reg <= spb_oe_n_i;
			spb_in_o <= spb_s2;
			port_b_flag_in_o <= 1'b0;
			if (alt_reg) begin
				spb_oe_n_reg <= {1'b0, 3'h7, spb_oe_n_i[SPB_SCLK]};
				spb_o_reg[SPB_DT] <= port_b_flag_out_i;
				spb_in_o <= {4'h0, spb_s2[SPB_SCLK]};
				port_b_flag_in_o <= spb_s2[SPB_DR];
			end
		end
	end
	assign spb_pin_o = spb_o_reg;
	assign spb_pin_oe_n_o = spb_oe_n_reg;

	// Shared bus pads follow the latched mode only
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			addr_o_reg <= '0;
			addr_oe_n_reg <= '1;
			data_o_reg <= '0;
			data_oe_n_reg <= '1;
		end else if (in_rst_reg) begin
			addr_oe_n_reg <= '1;
			data_oe_n_reg <= '1;
		end else if (!host) begin
			addr_o_reg <= ext_address_bus_i;
			addr_oe_n_reg <= '0;
			data_o_reg <= ext_data_bus_i;
			data_oe_n_reg <= {DATA_W{!ext_data_oe_i}};
			if (byte_dma_cycle_i) begin
				data_o_reg[DATA_W-1:BYTE_ADDR_LSB] <= byte_dma_addr_i;
				data_oe_n_reg[DATA_W-1:BYTE_ADDR_LSB] <= 8'h00;
			end
		end else begin
			addr_o_reg <= {host_addr_data_bus_i[12:0], ext_address_bus_i[0]};
			addr_oe_n_reg <= {{13{!host_addr_data_oe_i}}, 1'b0};
			data_o_reg <= {ext_data_bus_i[DATA_W-1:8], 5'h00,
				host_addr_data_bus_i[15:13]};
			data_oe_n_reg <= {{16{!ext_data_oe_i}}, 4'hF,
				!host_port_acknowledge_i, {3{!host_addr_data_oe_i}}};
		end
	end
	assign addr_pad_o = addr_o_reg;
	assign addr_pad_oe_n_o = addr_oe_n_reg;
	assign data_pad_o = data_o_reg;
	assign data_pad_oe_n_o = data_oe_n_reg;

	// Inbound pad values split by mode
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_data_bus_o <= '0;
			host_addr_data_bus_o <= '0;
			host_write_strobe_n_o <= 1'b1;
			host_read_strobe_n_o <= 1'b1;
			host_addr_latch_o <= 1'b0;
			host_port_select_n_o <= 1'b1;
		end else begin
			ext_data_bus_o <= host ? {data_s2[DATA_W-1:8], 8'h00} : data_s2;
			host_addr_data_bus_o <= host ? {data_s2[2:0], addr_s2[13:1]} : '0;
			host_write_strobe_n_o <= host ? data_s2[D_WR] : 1'b1;
			host_read_strobe_n_o <= host ? data_s2[D_RD] : 1'b1;
			host_addr_latch_o <= host ? data_s2[D_AL] : 1'b0;
			host_port_select_n_o <= host ? data_s2[D_SEL] : 1'b1;
		end
	end

	// Checks
	strap_frozen_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!in_rst_reg && !$past(in_rst_reg) |-> $stable(strap_reg)
		&& $stable(mode_reg)) else $error("strap changed after reset");
	flag_float_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		in_rst_reg |=> &pf_oe_n_reg) else $error("flag driven in reset");
	flag_drive_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!in_rst_reg && prog_flag_dir_i[0] |=> !pf_oe_n_reg[0]
		&& pf_o_reg[0] == $past(prog_flag_out_i[0]))
		else $error("flag zero not driven");
	dma_mode_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!in_rst_reg |=> byte_dma_port_en_o == (mode_reg == PMX_FULL_MEM)
		&& host_dma_port_en_o != byte_dma_port_en_o)
		else $error("dma port enable wrong");
	host_strobe_in_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!in_rst_reg && host |=> &data_oe_n_reg[D_WR:D_SEL])
		else $error("host strobe pad driven");
	full_addr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!in_rst_reg && !host |=> addr_oe_n_reg == '0
		&& addr_o_reg == $past(ext_address_bus_i))
		else $error("address not driven");
	byte_addr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!in_rst_reg && !host && byte_dma_cycle_i
		|=> data_o_reg[DATA_W-1:BYTE_ADDR_LSB] == $past(byte_dma_addr_i))
		else $error("byte address missing");
	level_int_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!int_lvl[INT_LVL_B] && interrupt_mask_i[INT_LVL_B]
		|=> int_req_reg[INT_LVL_B]) else $error("level request lost");
	edge_set_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		int_prev_reg[INT_EDGE] && !int_lvl[INT_EDGE] |=> pend_reg[INT_EDGE])
		else $error("edge not latched");
	sclk_kept_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		alt_reg |=> spb_o_reg[SPB_SCLK] == $past(spb_out_i[SPB_SCLK])
		&& spb_oe_n_reg[SPB_RFS] && !spb_oe_n_reg[SPB_DT])
		else $error("port b routing wrong");
endmodule // pmx_pin_mux

`default_nettype wire

// ===== rtl/pmx_pkg.sv
// Constants for the pin mode select and multiplexing block.
// Assumes a single processor clock and an active high master reset.
package pmx_pkg;
	// Pad group widths
	localparam int ADDR_W = 14;
	localparam int DATA_W = 24;
	localparam int HOST_W = 16;
	localparam int FLAG_N = 8;
	localparam int STRAP_N = 4;
	localparam int SPB_N = 5;
	localparam int INT_N = 6;
	// Strap that picks the memory configuration
	localparam int STRAP_MEM_BIT = 2;
	// Byte memory address sits on the upper data byte
	localparam int BYTE_ADDR_LSB = 16;
	// Interrupt slots
	localparam int INT_DUAL = 0;
	localparam int INT_LVL_B = 1;
	localparam int INT_LVL_A = 2;
	localparam int INT_EDGE = 3;
	localparam int INT_SPB0 = 4;
	localparam int INT_SPB1 = 5;
	// Flag pins shared with interrupts
	localparam int PF_DUAL = 7;
	localparam int PF_LVL_B = 6;
	localparam int PF_LVL_A = 5;
	localparam int PF_EDGE = 4;
	// Second serial port pin slots
	localparam int SPB_SCLK = 0;
	localparam int SPB_RFS = 1;
	localparam int SPB_TFS = 2;
	localparam int SPB_DR = 3;
	localparam int SPB_DT = 4;
	// Data pads that carry host port strobes in host mode
	localparam int D_WR = 7;
	localparam int D_RD = 6;
	localparam int D_AL = 5;
	localparam int D_SEL = 4;
	localparam int D_ACK = 3;
	// Values after reset
	localparam logic [INT_N-1:0] INT_RST = 6'h00;
	localparam logic [INT_N-1:0] LVL_IDLE = 6'h3F;
	// Operating mode latched from the strap
	typedef enum logic {
		PMX_FULL_MEM = 1'b0,
		PMX_HOST = 1'b1
	} pmx_mode_e;
endpackage

// ===== dv/pmx_pad_board.sv
// Board side of a group of pads: board drivers, pull-up or floating.
// Assumes the device drives a pad while its enable is low.
`timescale 1ns/1ns
`default_nettype none
module pmx_pad_board #(parameter int W = 8, parameter bit PULL = 0) (
	// Device side
	input wire logic [W-1:0] dev_o,
	input wire logic [W-1:0] dev_oe_n,
	// Board drivers
	input wire logic [W-1:0] brd_en,
	input wire logic [W-1:0] brd_val,
	// Resolved level seen by the device
	output logic [W-1:0] pin
);
	// Device wins, then board, then pull-up or the inverse of last value
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (!dev_oe_n[i]) pin[i] = dev_o[i];
			else if (brd_en[i]) pin[i] = brd_val[i];
			else pin[i] = PULL ? 1'b1 : ~dev_o[i];
		end
	end
endmodule // pmx_pad_board
`default_nettype wire

// ===== dv/test_pin_mode_select_mux.sv
// Self-checking bench for the pin mode select block.
// Assumes the pad board model resolves every pad group.
`timescale 1ns/1ns
`default_nettype none
module test_pin_mode_select_mux;
	import pmx_pkg::*;
`define CHK(n,e,s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
$display("mismatch %s exp %h got %h", n, e, s); end end
	typedef struct {logic [7:0] d, o, b, eoe, ein;} pmx_row_s;
	pmx_row_s rows[4] = '{'{8'hFF, 8'hA5, 8'h00, 8'h00, 8'hA5},
		'{8'h00, 8'h00, 8'h3C, 8'hFF, 8'h3C},
		'{8'h0F, 8'h06, 8'hC0, 8'hF0, 8'hC6},
		'{8'hF0, 8'h90, 8'h0B, 8'h0F, 8'h9B}};
	logic [5:0] emask[2] = '{6'h08, 6'h01};
	int epin[2] = '{4, 7};
	int bad_count = 0, num_checks = 0, cyc = 0;
	logic mclk_i = 0, sys_rst_i = 1, port_b_alt_i = 0, port_b_flag_out_i = 0;
	logic ext_data_oe_i = 0, byte_dma_cycle_i = 0, host_addr_data_oe_i = 0;
	logic host_port_acknowledge_i = 0, port_b_flag_in_o, byte_dma_port_en_o;
	logic host_write_strobe_n_o, host_read_strobe_n_o, host_addr_latch_o;
	logic host_port_select_n_o, host_dma_port_en_o;
	logic [7:0] prog_flag_pin_i, prog_flag_pin_o, prog_flag_pin_oe_n_o;
	logic [7:0] prog_flag_dir_i = 0, prog_flag_out_i = 0, prog_flag_in_o;
	logic [7:0] byte_dma_addr_i = 0, fb_en = 8'h0F, fb_val = 8'h0B;
	logic [5:0] interrupt_mask_i = 0, int_ack_i = 0, int_req_o;
	logic [2:0] int_edge_sel_i = 0;
	logic [4:0] spb_pin_i, spb_pin_o, spb_pin_oe_n_o, spb_in_o;
	logic [4:0] spb_out_i = 0, spb_oe_n_i = 5'h1F, sb_en = 0, sb_val = 0;
	logic [13:0] addr_pad_i, addr_pad_o, addr_pad_oe_n_o;
	logic [13:0] ext_address_bus_i = 0, ab_en = 0, ab_val = 0;
	logic [23:0] data_pad_i, data_pad_o, data_pad_oe_n_o, ext_data_bus_o;
	logic [23:0] ext_data_bus_i = 0, db_en = 0, db_val = 0;
	logic [15:0] host_addr_data_bus_i = 0, host_addr_data_bus_o;
	logic [3:0] mode_straps_o;
	// Device and board pad models
	pmx_pin_mux dut (.mclk_i, .sys_rst_i, .prog_flag_pin_i, .prog_flag_pin_o,
		.prog_flag_pin_oe_n_o, .prog_flag_dir_i, .prog_flag_out_i,
		.prog_flag_in_o, .interrupt_mask_i, .int_edge_sel_i, .int_ack_i,
		.int_req_o, .spb_pin_i, .spb_pin_o, .spb_pin_oe_n_o, .port_b_alt_i,
		.spb_out_i, .spb_oe_n_i, .spb_in_o, .port_b_flag_out_i,
		.port_b_flag_in_o, .addr_pad_i, .addr_pad_o, .addr_pad_oe_n_o,
		.data_pad_i, .data_pad_o, .data_pad_oe_n_o, .ext_address_bus_i,
		.ext_data_bus_i, .ext_data_oe_i, .ext_data_bus_o, .byte_dma_cycle_i,
		.byte_dma_addr_i, .host_addr_data_bus_i, .host_addr_data_oe_i,
		.host_addr_data_bus_o, .host_write_strobe_n_o, .host_read_strobe_n_o,
		.host_addr_latch_o, .host_port_select_n_o, .host_port_acknowledge_i,
		.mode_straps_o, .byte_dma_port_en_o, .host_dma_port_en_o);
	pmx_pad_board #(.W(8), .PULL(1)) u_flg (.dev_o(prog_flag_pin_o),
		.dev_oe_n(prog_flag_pin_oe_n_o), .brd_en(fb_en), .brd_val(fb_val),
		.pin(prog_flag_pin_i));
	pmx_pad_board #(.W(5)) u_spb (.dev_o(spb_pin_o), .dev_oe_n(spb_pin_oe_n_o),
		.brd_en(sb_en), .brd_val(sb_val), .pin(spb_pin_i));
	pmx_pad_board #(.W(14)) u_adr (.dev_o(addr_pad_o),
		.dev_oe_n(addr_pad_oe_n_o), .brd_en(ab_en), .brd_val(ab_val),
		.pin(addr_pad_i));
	pmx_pad_board #(.W(24)) u_dat (.dev_o(data_pad_o),
		.dev_oe_n(data_pad_oe_n_o), .brd_en(db_en), .brd_val(db_val),
		.pin(data_pad_i));
	// Clock and hang limit
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (++cyc == 2000) begin
			bad_count++;
			end_of_test;
		end
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task w(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task s(input int n);
		w(n);
		@(negedge mclk_i);
	endtask
	// Main sequence
	initial begin
		s(3);
		`CHK("rst oe_n", 8'hFF, prog_flag_pin_oe_n_o)
		`CHK("rst dma", 2'b00, {byte_dma_port_en_o, host_dma_port_en_o})
		w(5); sys_rst_i <= 0;
		w(2); fb_val <= 8'h04;
		s(6);
		`CHK("straps", 4'hB, mode_straps_o)
		`CHK("full dma", 2'b10, {byte_dma_port_en_o, host_dma_port_en_o})
		foreach (rows[i]) begin
			w(1); prog_flag_dir_i <= rows[i].d; prog_flag_out_i <= rows[i].o;
			fb_en <= ~rows[i].d; fb_val <= rows[i].b;
			s(5);
			`CHK("flag oe_n", rows[i].eoe, prog_flag_pin_oe_n_o)
			`CHK("flag out", rows[i].o & rows[i].d, prog_flag_pin_o & rows[i].d)
			`CHK("flag in", rows[i].ein, prog_flag_in_o)
		end
		`CHK("strap hold", 4'hB, mode_straps_o)
		w(1); ext_address_bus_i <= 14'h2A5C; ext_data_oe_i <= 1;
		ext_data_bus_i <= 24'h123456; byte_dma_cycle_i <= 1;
		byte_dma_addr_i <= 8'hC3;
		s(4);
		`CHK("addr", 14'h2A5C, addr_pad_o | addr_pad_oe_n_o)
		`CHK("data", 24'hC33456, data_pad_o | data_pad_oe_n_o)
		`CHK("data in", 24'hC33456, ext_data_bus_o)
		w(1); ext_data_oe_i <= 0; db_en <= 24'hFFFFFF; db_val <= 24'h0F1E2D;
		byte_dma_cycle_i <= 0;
		s(5);
		`CHK("data rd", 24'h0F1E2D, ext_data_bus_o)
		`CHK("strobes", 4'hD, {host_write_strobe_n_o, host_read_strobe_n_o,
			host_addr_latch_o, host_port_select_n_o})
		// Clear the edge left pending by the flag rows first
		w(1); prog_flag_dir_i <= 0; fb_en <= 8'hFF; fb_val <= 8'hDF;
		interrupt_mask_i <= 6'h0F; int_ack_i <= 6'h3F;
		w(1); int_ack_i <= 6'h00;
		s(3); `CHK("lvl req", 6'h04, int_req_o)
		w(1); interrupt_mask_i <= 6'h0B;
		s(3); `CHK("masked", 6'h00, int_req_o)
		w(1); fb_val <= 8'hFF; prog_flag_dir_i <= 8'h40; interrupt_mask_i <= 6'h3F;
		s(4); `CHK("sw req", 6'h02, int_req_o)
		foreach (epin[k]) begin
			w(1); prog_flag_out_i <= 8'h40; int_edge_sel_i <= 3'h1;
			fb_val[epin[k]] <= 1'b0;
			w(1); fb_val[epin[k]] <= 1'b1;
			s(5); `CHK("edge req", emask[k], int_req_o)
			w(1); int_ack_i <= emask[k];
			w(1); int_ack_i <= 6'h00;
			s(3); `CHK("edge ack", 6'h00, int_req_o)
		end
		w(1); port_b_alt_i <= 1; port_b_flag_out_i <= 1; spb_oe_n_i <= 5'h1E;
		spb_out_i <= 5'h01; sb_en <= 5'h0E; sb_val <= 5'h08; int_edge_sel_i <= 0;
		s(6);
		`CHK("spb oe_n", 5'h0E, spb_pin_oe_n_o)
		`CHK("spb out", 2'b11, {spb_pin_o[4], spb_pin_o[0]})
		`CHK("spb in", 5'h01, spb_in_o)
		`CHK("spb flag", 1'b1, port_b_flag_in_o)
		`CHK("spb req", 6'h30, int_req_o)
		w(1); port_b_alt_i <= 0;
		s(4);
		`CHK("spb back", 5'h1E, spb_pin_oe_n_o)
		`CHK("spb noreq", 6'h00, int_req_o)
		w(1); sys_rst_i <= 1; fb_en <= 8'h0F; fb_val <= 8'h04;
		prog_flag_dir_i <= 0; db_en <= 0;
		s(4); `CHK("rst2 req", 6'h00, int_req_o)
		w(4); sys_rst_i <= 0;
		w(1); host_addr_data_oe_i <= 1; host_addr_data_bus_i <= 16'hB5A3;
		ext_address_bus_i <= 14'h3FFF;
		s(5);
		`CHK("host dma", 2'b01, {byte_dma_port_en_o, host_dma_port_en_o})
		`CHK("host straps", 4'h4, mode_straps_o)
		`CHK("host wr", 16'hB5A3, {data_pad_o[2:0], addr_pad_o[13:1]})
		`CHK("a0", 1'b1, addr_pad_o[0])
		w(1); host_addr_data_oe_i <= 0; ab_en <= 14'h3FFE; ab_val <= 14'h0B46;
		db_en <= 24'h0000F7; db_val <= 24'h000065; host_port_acknowledge_i <= 1;
		s(5);
		`CHK("host rd", 16'hA5A3, host_addr_data_bus_o)
		`CHK("host strb", 4'h6, {host_write_strobe_n_o, host_read_strobe_n_o,
			host_addr_latch_o, host_port_select_n_o})
		`CHK("ack", 2'b00, {data_pad_o[3], data_pad_oe_n_o[3]})
		end_of_test;
	end
endmodule // test_pin_mode_select_mux
`default_nettype wire
